/* File: logic/flic_top.sv */
// Four-level interrupt controller top: arbitration, nesting and vectoring
`timescale 1ns/1ps
module flic_top (
  input  wire logic                       CLOCK_I,
  input  wire logic                       RST_I,
  input  wire flic_pkg::flic_cfg_t        CFG_I,
  input  wire logic                       EXT_PIN0_N_I,
  input  wire logic                       EXT_PIN1_N_I,
  input  wire logic                       EXT_PIN0_EDGE_I,
  input  wire logic                       EXT_PIN1_EDGE_I,
  input  wire logic                       TIMER0_OVERFLOW_FLAG_I,
  input  wire logic                       TIMER1_OVERFLOW_FLAG_I,
  input  wire logic                       SERIAL_TX_FLAG_I,
  input  wire logic                       SERIAL_RX_FLAG_I,
  input  wire logic                       BROWNOUT_FLAG_I,
  input  wire logic                       TWOWIRE_ATTENTION_FLAG_I,
  input  wire logic                       KEYBOARD_FLAG_I,
  input  wire logic                       COMPARATOR1_FLAG_I,
  input  wire logic                       COMPARATOR2_FLAG_I,
  input  wire logic                       WATCHDOG_OVERFLOW_FLAG_I,
  input  wire logic                       BUS_TIMEOUT_FLAG_I,
  input  wire logic                       IRQ_ACK_I,
  input  wire logic                       IRQ_RETURN_I,
  output logic                            IRQ_REQ_O,
  output logic [flic_pkg::VEC_W-1:0]      IRQ_VECTOR_O,
  output logic [flic_pkg::IDX_W-1:0]      IRQ_SOURCE_O,
  output flic_pkg::flic_lvl_t             ACTIVE_LEVEL_O,
  output logic                            IN_SERVICE_O,
  output logic                            WAKE_O,
  output logic [flic_pkg::NUM_SRC-1:0]    PENDING_O
);
  import flic_pkg::*;

  // ------------------------------------------------------------------
  // Machine-cycle enable
  // ------------------------------------------------------------------
  logic [2:0] div_r;
  logic       mcyc_en;

  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      div_r <= 3'h0;
    end else if (div_r == 3'(MCYC_DIV - 1)) begin
      div_r <= 3'h0;
    end else begin
      div_r <= div_r + 3'h1;
    end
  end

  assign mcyc_en = (div_r == 3'(MCYC_DIV - 1));

  // ------------------------------------------------------------------
  // Source flags
  // ------------------------------------------------------------------
  logic                   ext0_flag;
  logic                   ext1_flag;
  logic                   ack_ext0;
  logic                   ack_ext1;
  logic                   take;
  logic [NUM_SRC-1:0]     raw;
  logic [NUM_SRC-1:0]     en_vec;
  logic [NUM_SRC-1:0]     hi_vec;
  logic [NUM_SRC-1:0]     lo_vec;
  logic [NUM_SRC-1:0]     req;
  flic_win_t              win;

  // An accept only counts while the request is shown to the core
  assign take     = IRQ_ACK_I && IRQ_REQ_O;
  assign ack_ext0 = take && (win.index == SRC_EXT0);
  assign ack_ext1 = take && (win.index == SRC_EXT1);

  flic_extpin u_ext0 (
    .CLOCK_I     (CLOCK_I),
    .RST_I       (RST_I),
    .mcyc_en_i   (mcyc_en),
    .pin_n_i     (EXT_PIN0_N_I),
    .edge_mode_i (EXT_PIN0_EDGE_I),
    .ack_i       (ack_ext0),
    .flag_o      (ext0_flag)
  );

  flic_extpin u_ext1 (
    .CLOCK_I     (CLOCK_I),
    .RST_I       (RST_I),
    .mcyc_en_i   (mcyc_en),
    .pin_n_i     (EXT_PIN1_N_I),
    .edge_mode_i (EXT_PIN1_EDGE_I),
    .ack_i       (ack_ext1),
    .flag_o      (ext1_flag)
  );

  always_comb begin
    raw           = '0;
    raw[SRC_EXT0] = ext0_flag;
    raw[SRC_TMR0] = TIMER0_OVERFLOW_FLAG_I;
    raw[SRC_EXT1] = ext1_flag;
    raw[SRC_TMR1] = TIMER1_OVERFLOW_FLAG_I;
    raw[SRC_SER]  = SERIAL_TX_FLAG_I | SERIAL_RX_FLAG_I;
    raw[SRC_BOD]  = BROWNOUT_FLAG_I;
    raw[SRC_WDG]  = WATCHDOG_OVERFLOW_FLAG_I;
    raw[SRC_TWI]  = TWOWIRE_ATTENTION_FLAG_I;
    raw[SRC_KBD]  = KEYBOARD_FLAG_I;
    raw[SRC_CMP2] = COMPARATOR2_FLAG_I;
    raw[SRC_CMP1] = COMPARATOR1_FLAG_I;
    raw[SRC_TOUT] = BUS_TIMEOUT_FLAG_I;
  end

  // ------------------------------------------------------------------
  // Enable and priority vectors gathered from the three register pairs
  // ------------------------------------------------------------------
  always_comb begin
    en_vec = '0;
    hi_vec = '0;
    lo_vec = '0;
    en_vec[REGA_SRC_BITS-1:0] = CFG_I.enable_a[REGA_SRC_BITS-1:0];
    hi_vec[REGA_SRC_BITS-1:0] = CFG_I.prio_high_a[REGA_SRC_BITS-1:0];
    lo_vec[REGA_SRC_BITS-1:0] = CFG_I.prio_low_a[REGA_SRC_BITS-1:0];
    en_vec[SRC_TWI]  = CFG_I.enable_b[REGB_TWI];
    en_vec[SRC_KBD]  = CFG_I.enable_b[REGB_KBD];
    en_vec[SRC_CMP2] = CFG_I.enable_b[REGB_CMP2];
    en_vec[SRC_CMP1] = CFG_I.enable_b[REGB_CMP1];
    en_vec[SRC_TOUT] = CFG_I.enable_b[REGB_TOUT];
    hi_vec[SRC_TWI]  = CFG_I.prio_high_b[REGB_TWI];
    hi_vec[SRC_KBD]  = CFG_I.prio_high_b[REGB_KBD];
    hi_vec[SRC_CMP2] = CFG_I.prio_high_b[REGB_CMP2];
    hi_vec[SRC_CMP1] = CFG_I.prio_high_b[REGB_CMP1];
    hi_vec[SRC_TOUT] = CFG_I.prio_high_b[REGB_TOUT];
    lo_vec[SRC_TWI]  = CFG_I.prio_low_b[REGB_TWI];
    lo_vec[SRC_KBD]  = CFG_I.prio_low_b[REGB_KBD];
    lo_vec[SRC_CMP2] = CFG_I.prio_low_b[REGB_CMP2];
    lo_vec[SRC_CMP1] = CFG_I.prio_low_b[REGB_CMP1];
    lo_vec[SRC_TOUT] = CFG_I.prio_low_b[REGB_TOUT];
  end

  assign req = raw & en_vec & {NUM_SRC{CFG_I.enable_a[GLOBAL_BIT]}};

  // ------------------------------------------------------------------
  // Nesting stack: one in-service bit per level
  // ------------------------------------------------------------------
  logic [NUM_LVL-1:0] busy_r;
  logic               any_busy;
  flic_lvl_t          cur_lvl;

  always_comb begin
    cur_lvl = '0;
    for (int l = 0; l < NUM_LVL; l++) begin
      if (busy_r[l]) cur_lvl = LVL_W'(l);
    end
  end

  assign any_busy = |busy_r;

  // ------------------------------------------------------------------
  // Arbitration: highest level first, poll order breaks ties
  // ------------------------------------------------------------------
  always_comb begin
    flic_lvl_t           lv;
    logic [IDX_W-1:0]    s;
    win = '0;
    lv  = '0;
    s   = '0;
    for (int r = 0; r < NUM_SRC; r++) begin
      s  = poll_src(r);
      lv = {hi_vec[s], lo_vec[s]};
      // Strictly greater keeps the earlier-polled source on a tie
      if (req[s] && (!win.valid || lv > win.level)) begin
        win.valid = 1'b1;
        win.index = s;
        win.level = lv;
      end
    end
    // Only strictly higher than the running level may preempt
    if (any_busy && (cur_lvl == LVL_TOP || win.level <= cur_lvl)) begin
      win.valid = 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // Accept and return
  // ------------------------------------------------------------------
  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      busy_r <= '0;
    end else if (take) begin
      busy_r[win.level] <= 1'b1;
    end else if (IRQ_RETURN_I && any_busy) begin
      busy_r[cur_lvl] <= 1'b0;
    end
  end

  logic [VEC_W-1:0] vec_r;
  logic [IDX_W-1:0] src_r;

  // Vector registered so the core sees a stable address next to the request
  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      vec_r <= '0;
      src_r <= '0;
    end else begin
      vec_r <= vector_of(win.index);
      src_r <= win.index;
    end
  end

  logic req_r;

  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      req_r <= 1'b0;
    end else begin
      req_r <= win.valid && !take;
    end
  end

  // Held back a cycle when the winner switches, so the vector never lags the request
  assign IRQ_REQ_O      = req_r && win.valid && (win.index == src_r);
  assign IRQ_VECTOR_O   = vec_r;
  assign IRQ_SOURCE_O   = src_r;
  assign ACTIVE_LEVEL_O = cur_lvl;
  assign IN_SERVICE_O   = any_busy;
  assign PENDING_O      = raw;
  // Wake ignores the global enable so power down can end on any enabled waker
  assign WAKE_O         = |(raw & en_vec & WAKE_MASK);
endmodule

/* File: logic/flic_pkg.sv */
// Package for the four-level interrupt controller: constants, layouts, types
// Functional notes
// - Up to twelve request sources, each at one of four levels.
// - Each source has its own enable bit; cleared blocks service.
// - Global enable bit in enable register A; cleared blocks every source.
// - Level chosen per source by one high-register and one low-register bit.
// - Running routine is preempted only by a strictly higher level.
// - A routine at the top level is never preempted.
// - Simultaneous requests of different levels: higher level wins.
// - Equal-level ties broken by fixed polling order only.
// - Poll order: ext0, brownout, watchdog, timer0, two-wire, ext1, keyboard, ...
// - Each source presents its own fixed vector address.
// - Only ext pins, brownout, keyboard, comparators, watchdog wake from power down.
// - Serial transmit or receive flag forms one shared request, bit 4.
// - Edge mode: pin flag set on high sample followed by low sample.
// - Edge-mode pin flag cleared when its routine is entered.
// - Level mode: pin flag follows the inverted pin level directly.
package flic_pkg;

  localparam int NUM_SRC   = 12;
  localparam int LVL_W     = 2;
  localparam int VEC_W     = 16;
  localparam int IDX_W     = 4;
  localparam int NUM_LVL   = 4;
  localparam int MCYC_DIV  = 6;

  typedef logic [LVL_W-1:0] flic_lvl_t;

  // Source index equals bit position in the enable and priority vectors
  localparam logic [IDX_W-1:0] SRC_EXT0 = 4'h0;
  localparam logic [IDX_W-1:0] SRC_TMR0 = 4'h1;
  localparam logic [IDX_W-1:0] SRC_EXT1 = 4'h2;
  localparam logic [IDX_W-1:0] SRC_TMR1 = 4'h3;
  localparam logic [IDX_W-1:0] SRC_SER  = 4'h4;
  localparam logic [IDX_W-1:0] SRC_BOD  = 4'h5;
  localparam logic [IDX_W-1:0] SRC_WDG  = 4'h6;
  localparam logic [IDX_W-1:0] SRC_TWI  = 4'h7;
  localparam logic [IDX_W-1:0] SRC_KBD  = 4'h8;
  localparam logic [IDX_W-1:0] SRC_CMP2 = 4'h9;
  localparam logic [IDX_W-1:0] SRC_CMP1 = 4'hA;
  localparam logic [IDX_W-1:0] SRC_TOUT = 4'hB;

  // Register A bit positions: bits 0..6 map to sources 0..6, bit 7 global
  localparam int REGA_SRC_BITS = 7;
  localparam int GLOBAL_BIT    = 7;
  // Register B bit positions of two-wire, keyboard, comparator 2/1, timeout
  localparam int REGB_TWI  = 0;
  localparam int REGB_KBD  = 1;
  localparam int REGB_CMP2 = 2;
  localparam int REGB_CMP1 = 5;
  localparam int REGB_TOUT = 7;

  localparam logic [NUM_SRC-1:0] WAKE_MASK = 12'h765;

  localparam logic [7:0] REG_RST = 8'h00;
  localparam flic_lvl_t  LVL_TOP = 2'h3;

  typedef struct packed {
    logic [7:0] enable_a;
    logic [7:0] enable_b;
    logic [7:0] prio_low_a;
    logic [7:0] prio_high_a;
    logic [7:0] prio_low_b;
    logic [7:0] prio_high_b;
  } flic_cfg_t;

  typedef struct packed {
    logic             valid;
    logic [IDX_W-1:0] index;
    flic_lvl_t        level;
  } flic_win_t;

  function automatic logic [VEC_W-1:0] vector_of(input logic [IDX_W-1:0] idx);
    case (idx)
      SRC_EXT0: vector_of = 16'h0003;
      SRC_TMR0: vector_of = 16'h000B;
      SRC_EXT1: vector_of = 16'h0013;
      SRC_TMR1: vector_of = 16'h001B;
      SRC_SER:  vector_of = 16'h0023;
      SRC_BOD:  vector_of = 16'h002B;
      SRC_TWI:  vector_of = 16'h0033;
      SRC_KBD:  vector_of = 16'h003B;
      SRC_CMP2: vector_of = 16'h0043;
      SRC_WDG:  vector_of = 16'h0053;
      SRC_CMP1: vector_of = 16'h0063;
      default:  vector_of = 16'h0073;
    endcase
  endfunction

  // Poll rank position -> source index
  function automatic logic [IDX_W-1:0] poll_src(input int rank);
    case (rank)
      0:       poll_src = SRC_EXT0;
      1:       poll_src = SRC_BOD;
      2:       poll_src = SRC_WDG;
      3:       poll_src = SRC_TMR0;
      4:       poll_src = SRC_TWI;
      5:       poll_src = SRC_EXT1;
      6:       poll_src = SRC_KBD;
      7:       poll_src = SRC_CMP1;
      8:       poll_src = SRC_TMR1;
      9:       poll_src = SRC_CMP2;
      10:      poll_src = SRC_SER;
      default: poll_src = SRC_TOUT;
    endcase
  endfunction

endpackage

/* File: logic/flic_extpin.sv */
// External pin request flag with edge or level mode
`timescale 1ns/1ps
module flic_extpin (
  input  wire logic CLOCK_I,
  input  wire logic RST_I,
  input  wire logic mcyc_en_i,
  input  wire logic pin_n_i,
  input  wire logic edge_mode_i,
  input  wire logic ack_i,
  output logic      flag_o
);
  logic prev_r;
  logic edge_flag_r;

  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      prev_r <= 1'b1;
    end else if (mcyc_en_i) begin
      prev_r <= pin_n_i;
    end
  end

  // Set beats the acknowledge clear so a fresh edge is never lost
  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      edge_flag_r <= 1'b0;
    end else if (mcyc_en_i && prev_r && !pin_n_i) begin
      edge_flag_r <= 1'b1;
    end else if (ack_i) begin
      edge_flag_r <= 1'b0;
    end
  end

  assign flag_o = edge_mode_i ? edge_flag_r : !pin_n_i;
endmodule

/* File: tb/flic_props.sv */
// Checker of the interrupt controller top ports
`timescale 1ns/1ps
module flic_props
  import flic_pkg::*;
(
  input wire logic             CLOCK_I,
  input wire logic             RST_I,
  input wire flic_cfg_t        CFG_I,
  input wire logic             SERIAL_TX_FLAG_I,
  input wire logic             SERIAL_RX_FLAG_I,
  input wire logic             IRQ_ACK_I,
  input wire logic             IRQ_REQ_O,
  input wire logic [VEC_W-1:0] IRQ_VECTOR_O,
  input wire logic [IDX_W-1:0] IRQ_SOURCE_O,
  input wire flic_lvl_t        ACTIVE_LEVEL_O,
  input wire logic             IN_SERVICE_O,
  input wire logic             WAKE_O,
  input wire logic [11:0]      PENDING_O
);
  localparam logic [15:0] VT [12] = '{16'h0003, 16'h000B, 16'h0013, 16'h001B, 16'h0023,
    16'h002B, 16'h0053, 16'h0033, 16'h003B, 16'h0043, 16'h0063, 16'h0073};
  function automatic logic [11:0] pick(input logic [7:0] a, input logic [7:0] b);
    return {b[7], b[5], b[2:0], a[6:0]};
  endfunction
  wire [11:0] en = pick(CFG_I.enable_a, CFG_I.enable_b);
  wire [11:0] hi = pick(CFG_I.prio_high_a, CFG_I.prio_high_b);
  wire [11:0] lo = pick(CFG_I.prio_low_a, CFG_I.prio_low_b);
  // ------------------------------------------------------------
  // Arbitration, nesting and wake properties
  // ------------------------------------------------------------
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (RST_I);
  property p_gie; !CFG_I.enable_a[7] && $past(!CFG_I.enable_a[7]) |-> !IRQ_REQ_O; endproperty
  a_gie: assert property (p_gie) else $error("request while globally off");
  property p_en; IRQ_REQ_O |-> en[IRQ_SOURCE_O]; endproperty
  a_en: assert property (p_en) else $error("request from disabled source");
  property p_lvl; IRQ_REQ_O && IN_SERVICE_O |->
    {hi[IRQ_SOURCE_O], lo[IRQ_SOURCE_O]} > ACTIVE_LEVEL_O; endproperty
  a_lvl: assert property (p_lvl) else $error("preempt not higher");
  property p_top; ACTIVE_LEVEL_O == 2'h3 && $past(ACTIVE_LEVEL_O) == 2'h3 |-> !IRQ_REQ_O;
  endproperty
  a_top: assert property (p_top) else $error("top level preempted");
  property p_vec; IRQ_REQ_O |-> IRQ_VECTOR_O == VT[IRQ_SOURCE_O]; endproperty
  a_vec: assert property (p_vec) else $error("vector mismatch");
  property p_ack; IRQ_REQ_O && IRQ_ACK_I |=> !IRQ_REQ_O && IN_SERVICE_O; endproperty
  a_ack: assert property (p_ack) else $error("accept not taken");
  property p_ins; $rose(IN_SERVICE_O) |-> $past(IRQ_ACK_I && IRQ_REQ_O); endproperty
  a_ins: assert property (p_ins) else $error("service without accept");
  property p_wake; WAKE_O == |(PENDING_O & en & 12'h765); endproperty
  a_wake: assert property (p_wake) else $error("wake mismatch");
  property p_ser; PENDING_O[4] == (SERIAL_TX_FLAG_I | SERIAL_RX_FLAG_I); endproperty
  a_ser: assert property (p_ser) else $error("serial flag mismatch");
endmodule
bind flic_top flic_props u_props (.CLOCK_I, .RST_I, .CFG_I, .SERIAL_TX_FLAG_I,
  .SERIAL_RX_FLAG_I, .IRQ_ACK_I, .IRQ_REQ_O, .IRQ_VECTOR_O, .IRQ_SOURCE_O,
  .ACTIVE_LEVEL_O, .IN_SERVICE_O, .WAKE_O, .PENDING_O);

/* File: tb/flic_core_model.sv */
// Core-side model that accepts vectored requests and signals returns
`timescale 1ns/1ps
module flic_core_model (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic req_i,
  input  wire logic run_i,
  input  wire logic ret_cmd_i,
  output logic      ack_o,
  output logic      ret_o
);
  int   depth = 0;
  logic a, r;
  initial ack_o = 1'b0;
  initial ret_o = 1'b0;
  // Random accept delay covers prompt and slow cores; never acks twice in a row
  always @(posedge clk_i) begin
    a = !rst_i && req_i && run_i && !ack_o && ($urandom_range(2) == 0);
    r = !rst_i && !a && !ack_o && ret_cmd_i && depth > 0;
    ack_o <= a;
    ret_o <= r;
    depth = rst_i ? 0 : depth + int'(a) - int'(r);
  end
endmodule

/* File: tb/flic_top_tb.sv */
// Self-checking testbench of the four-level interrupt controller
`timescale 1ns/1ps
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin fail_count++; \
  $display("CHECK FAILED %s expected %0h seen %0h", n, e, s); end end
module flic_top_tb;
  import flic_pkg::*;
  logic        clk = 1'b0, rst = 1'b1, pen = 1'b0, rcmd = 1'b0, ack, ret, req, ins, wake;
  logic        tx = 1'b0, rx = 1'b0, p0 = 1'b1, p1 = 1'b1, e0 = 1'b0;
  logic [11:0] fl = '0, pend;
  flic_cfg_t   cfg = '0, c;
  logic [15:0] vec;
  logic [3:0]  src;
  logic [1:0]  alv;
  int          fail_count = 0, checks_done = 0, stk[$];
  localparam int RK [12] = '{0, 3, 5, 8, 10, 1, 2, 4, 6, 9, 7, 11};
  localparam logic [15:0] VT [12] = '{16'h0003, 16'h000B, 16'h0013, 16'h001B, 16'h0023,
    16'h002B, 16'h0053, 16'h0033, 16'h003B, 16'h0043, 16'h0063, 16'h0073};
  function automatic logic [11:0] pick(input logic [7:0] a, input logic [7:0] b);
    return {b[7], b[5], b[2:0], a[6:0]};
  endfunction
  wire [11:0] en = pick(cfg.enable_a, cfg.enable_b);
  wire [11:0] hi = pick(cfg.prio_high_a, cfg.prio_high_b);
  wire [11:0] lo = pick(cfg.prio_low_a, cfg.prio_low_b);
  function automatic int lv(input int i);
    return {hi[i], lo[i]};
  endfunction
  function automatic int win();
    logic [11:0] p;
    int w;
    p = {fl[11:5], tx | rx, fl[3], !p1, fl[1], !p0};
    w = -1;
    for (int i = 0; i < 12; i++)
      if (p[i] && en[i] && cfg.enable_a[7] && (stk.size() == 0 || lv(i) > stk[$]))
        if (w < 0 || lv(i) > lv(w) || (lv(i) == lv(w) && RK[i] < RK[w])) w = i;
    return w;
  endfunction
  flic_top dut (.CLOCK_I(clk), .RST_I(rst), .CFG_I(cfg), .EXT_PIN0_N_I(p0),
    .EXT_PIN1_N_I(p1), .EXT_PIN0_EDGE_I(e0), .EXT_PIN1_EDGE_I(e0),
    .TIMER0_OVERFLOW_FLAG_I(fl[1]), .TIMER1_OVERFLOW_FLAG_I(fl[3]),
    .SERIAL_TX_FLAG_I(tx), .SERIAL_RX_FLAG_I(rx), .BROWNOUT_FLAG_I(fl[5]),
    .TWOWIRE_ATTENTION_FLAG_I(fl[7]), .KEYBOARD_FLAG_I(fl[8]),
    .COMPARATOR1_FLAG_I(fl[10]), .COMPARATOR2_FLAG_I(fl[9]),
    .WATCHDOG_OVERFLOW_FLAG_I(fl[6]), .BUS_TIMEOUT_FLAG_I(fl[11]), .IRQ_ACK_I(ack),
    .IRQ_RETURN_I(ret), .IRQ_REQ_O(req), .IRQ_VECTOR_O(vec), .IRQ_SOURCE_O(src),
    .ACTIVE_LEVEL_O(alv), .IN_SERVICE_O(ins), .WAKE_O(wake), .PENDING_O(pend));
  flic_core_model core (.clk_i(clk), .rst_i(rst), .req_i(req), .run_i(pen),
    .ret_cmd_i(rcmd), .ack_o(ack), .ret_o(ret));
  initial forever #20 clk = ~clk;
  // ------------------------------------------------------------
  // Model update at every accept and return; owners clear their flags
  // ------------------------------------------------------------
  always @(posedge clk) begin
    int w;
    w = win();
    if (!rst && ack && req) begin
      `CHK("source", w[3:0], src)
      `CHK("vector", VT[w[3:0]], vec)
      stk.push_back(lv(w[3:0]));
      fl[w[3:0]] <= 1'b0;
      if (w == 4) {tx, rx} <= 2'b00;
      if (w == 0 && !e0) p0 <= 1'b1;
      if (w == 2) p1 <= 1'b1;
    end else if (!rst && ret && stk.size() > 0) void'(stk.pop_back());
  end
  task automatic settle_chk();
    @(negedge clk);
    `CHK("request", 1'(win() >= 0), req)
    `CHK("level", 2'(stk.size() ? stk[$] : 0), alv)
    `CHK("in service", 1'(stk.size() > 0), ins)
    `CHK("wake", |({fl[11:5], tx | rx, fl[3], !p1, fl[1], !p0} & en & 12'h765), wake)
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #(40 * 8000);
    fail_count++;
    final_report();
  end
  initial begin
    void'($urandom(59605));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    e0 <= 1'b1;
    cfg <= {8'h81, 40'h0};
    repeat (14) @(posedge clk);
    {p0, p1} <= 2'b00;
    repeat (14) @(posedge clk);
    @(negedge clk);
    `CHK("edge set", 1'b1, pend[0])
    `CHK("edge set pin 1", 1'b1, pend[2])
    @(posedge clk);
    pen <= 1'b1;
    for (int k = 0; k < 60 && ins !== 1'b1; k++) @(posedge clk);
    pen <= 1'b0;
    @(negedge clk);
    `CHK("edge clear", 1'b0, pend[0])
    `CHK("edge kept pin 1", 1'b1, pend[2])
    repeat (80) begin
      @(posedge clk);
      {fl, tx, rx, p0, p1, e0} <= {12'h000, 5'b00110};
      repeat (8) @(posedge clk);
      rcmd <= 1'($urandom_range(1));
      repeat (4) @(posedge clk);
      rcmd <= 1'b0;
      c = {$urandom, 16'($urandom)};
      c.enable_a[7] = ($urandom_range(3) != 0);
      cfg <= c;
      {fl, tx, rx, p0, p1} <= 16'($urandom);
      repeat (10) @(posedge clk);
      settle_chk();
      `CHK("pin level", !p0, pend[0])
      `CHK("serial", tx | rx, pend[4])
      @(posedge clk);
      pen <= 1'b1;
      repeat (30) @(posedge clk);
      pen <= 1'b0;
      repeat (4) @(posedge clk);
      settle_chk();
    end
    final_report();
  end
endmodule
